// [rcr_top.sv]
// rail control register bank: three rail registers, sleep handling, decode
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
module rcr_top #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // sleep input
  input wire logic SLEEP_N,
  // deep-sleep 3.3 V rail
  output logic DS_CONV_EN,
  output logic DS_CONV_FPWM,
  output logic [1:0] DS_VOLT_SEL,
  output logic [1:0] DS_LP_SEL,
  output logic DS_LP_ACTIVE,
  // platform 3.3 V switch
  output logic PSW_EN,
  // 1.8 V rail
  output logic V18_CONV_EN,
  output logic V18_CONV_FPWM,
  output logic [1:0] V18_VOLT_SEL,
  output logic [1:0] V18_LP_SEL,
  output logic V18_LP_ACTIVE
);

  ////////////////////////////////////////////////////////////////////////////
  // bus front end

  logic wr_pulse, wr_lane0, wr_ok, rd_ok;
  logic [ADDR_W-1:0] wr_addr, rd_addr;
  logic [7:0] wr_data, rd_data;
  logic [7:0] ds_val, psw_val, v18_val;
  logic wr_ds, wr_psw, wr_v18;

  rcr_axil_slave #(.ADDR_W(ADDR_W)) u_bus (
    .clk(CLK),
    .arst_n(ARST_N),
    .awaddr(S_AXI_AWADDR),
    .awvalid(S_AXI_AWVALID),
    .awready(S_AXI_AWREADY),
    .wdata(S_AXI_WDATA),
    .wstrb(S_AXI_WSTRB),
    .wvalid(S_AXI_WVALID),
    .wready(S_AXI_WREADY),
    .bresp(S_AXI_BRESP),
    .bvalid(S_AXI_BVALID),
    .bready(S_AXI_BREADY),
    .araddr(S_AXI_ARADDR),
    .arvalid(S_AXI_ARVALID),
    .arready(S_AXI_ARREADY),
    .rdata(S_AXI_RDATA),
    .rresp(S_AXI_RRESP),
    .rvalid(S_AXI_RVALID),
    .rready(S_AXI_RREADY),
    .wr_pulse(wr_pulse),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_lane0(wr_lane0),
    .wr_ok(wr_ok),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  // lane 0 holds the whole register; other lanes are ignored
  assign wr_ds = wr_pulse && wr_lane0 && wr_addr == ADDR_W'(rcr_pkg::ADDR_DEEP_SLEEP);
  assign wr_psw = wr_pulse && wr_lane0 && wr_addr == ADDR_W'(rcr_pkg::ADDR_PLAT_SWITCH);
  assign wr_v18 = wr_pulse && wr_lane0 && wr_addr == ADDR_W'(rcr_pkg::ADDR_RAIL_1V8);
  assign wr_ok = wr_addr == ADDR_W'(rcr_pkg::ADDR_DEEP_SLEEP)
    || wr_addr == ADDR_W'(rcr_pkg::ADDR_PLAT_SWITCH)
    || wr_addr == ADDR_W'(rcr_pkg::ADDR_RAIL_1V8);

  always_comb begin
    rd_data = 8'h00;
    rd_ok = 1'b1;
    if (rd_addr == ADDR_W'(rcr_pkg::ADDR_DEEP_SLEEP)) begin
      rd_data = ds_val;
    end else if (rd_addr == ADDR_W'(rcr_pkg::ADDR_PLAT_SWITCH)) begin
      rd_data = psw_val;
    end else if (rd_addr == ADDR_W'(rcr_pkg::ADDR_RAIL_1V8)) begin
      rd_data = v18_val;
    end else begin
      rd_ok = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sleep edges

  logic sleep_prev_reg, sleep_prev_next;
  logic enter_pulse, exit_pulse;

  assign sleep_prev_next = SLEEP_N;
  assign enter_pulse = sleep_prev_reg && !SLEEP_N;
  // one pulse per rise, since prev follows the pin every cycle
  assign exit_pulse = !sleep_prev_reg && SLEEP_N;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sleep_prev_reg <= 1'b1;
    end else begin
      sleep_prev_reg <= sleep_prev_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // rail registers

  rcr_rail_reg #(.RESET_VAL(rcr_pkg::RST_DEEP_SLEEP)) u_ds (
    .clk(CLK),
    .arst_n(ARST_N),
    .wr_en(wr_ds),
    .wr_data(wr_data),
    .exit_pulse(exit_pulse),
    .value(ds_val)
  );

  rcr_rail_reg #(.RESET_VAL(rcr_pkg::RST_PLAT_SWITCH)) u_psw (
    .clk(CLK),
    .arst_n(ARST_N),
    .wr_en(wr_psw),
    .wr_data(wr_data),
    .exit_pulse(exit_pulse),
    .value(psw_val)
  );

  rcr_rail_reg #(.RESET_VAL(rcr_pkg::RST_RAIL_1V8)) u_v18 (
    .clk(CLK),
    .arst_n(ARST_N),
    .wr_en(wr_v18),
    .wr_data(wr_data),
    .exit_pulse(exit_pulse),
    .value(v18_val)
  );

  ////////////////////////////////////////////////////////////////////////////
  // rail controls

  logic [1:0] ds_mode, v18_mode, psw_mode;
  logic [1:0] ds_lp_reg, ds_lp_next, v18_lp_reg, v18_lp_next;
  logic [6:0] out_reg, out_next;

  assign ds_mode = ds_val[rcr_pkg::MODE_MSB:rcr_pkg::MODE_LSB];
  assign v18_mode = v18_val[rcr_pkg::MODE_MSB:rcr_pkg::MODE_LSB];
  assign psw_mode = psw_val[rcr_pkg::MODE_MSB:rcr_pkg::MODE_LSB];

  // setpoint is taken at the falling edge only; later writes wait for the next entry
  always_comb begin
    ds_lp_next = ds_lp_reg;
    v18_lp_next = v18_lp_reg;
    if (enter_pulse) begin
      ds_lp_next = ds_val[rcr_pkg::LP_MSB:rcr_pkg::LP_LSB];
      v18_lp_next = v18_val[rcr_pkg::LP_MSB:rcr_pkg::LP_LSB];
    end else if (exit_pulse) begin
      ds_lp_next = rcr_pkg::LP_NONE;
      v18_lp_next = rcr_pkg::LP_NONE;
    end
  end

  always_comb begin
    out_next[0] = ds_mode != rcr_pkg::MODE_OFF;
    out_next[1] = ds_mode == rcr_pkg::MODE_FPWM;
    out_next[2] = psw_mode != rcr_pkg::MODE_OFF;
    out_next[3] = v18_mode != rcr_pkg::MODE_OFF;
    out_next[4] = v18_mode == rcr_pkg::MODE_FPWM;
    out_next[5] = ds_lp_next != rcr_pkg::LP_NONE;
    out_next[6] = v18_lp_next != rcr_pkg::LP_NONE;
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ds_lp_reg <= 2'h0;
      v18_lp_reg <= 2'h0;
      out_reg <= 7'h0D;
    end else begin
      ds_lp_reg <= ds_lp_next;
      v18_lp_reg <= v18_lp_next;
      out_reg <= out_next;
    end
  end

  assign DS_CONV_EN = out_reg[0];
  assign DS_CONV_FPWM = out_reg[1];
  assign PSW_EN = out_reg[2];
  assign V18_CONV_EN = out_reg[3];
  assign V18_CONV_FPWM = out_reg[4];
  assign DS_LP_ACTIVE = out_reg[5];
  assign V18_LP_ACTIVE = out_reg[6];
  assign DS_LP_SEL = ds_lp_reg;
  assign V18_LP_SEL = v18_lp_reg;
  // normal select is a straight register field, so it is already a flop
  assign DS_VOLT_SEL = ds_val[rcr_pkg::VSEL_MSB:rcr_pkg::VSEL_LSB];
  assign V18_VOLT_SEL = v18_val[rcr_pkg::VSEL_MSB:rcr_pkg::VSEL_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_exit_code(logic [1:0] code);
    exit_pulse && !wr_pulse && ds_val[3:2] == code;
  endsequence

  property p_ds_lp_apply;
    @(posedge CLK) disable iff (!ARST_N)
      enter_pulse |=> DS_LP_SEL == $past(ds_val[7:6])
        && DS_LP_ACTIVE == ($past(ds_val[7:6]) != 2'h0);
  endproperty
  a_ds_lp_apply: assert property (p_ds_lp_apply) else $error("deep-sleep lp not applied");

  property p_ds_lp_none;
    @(posedge CLK) disable iff (!ARST_N)
      (enter_pulse && !wr_ds && ds_val[7:6] == 2'h0) |=> !DS_LP_ACTIVE && DS_LP_SEL == 2'h0
        && $stable(DS_VOLT_SEL);
  endproperty
  a_ds_lp_none: assert property (p_ds_lp_none) else $error("deep-sleep lp 00 moved voltage");

  property p_exit_copy;
    @(posedge CLK) disable iff (!ARST_N)
      (exit_pulse && !wr_pulse && ds_val[3:2] != 2'h0) |=> ds_val[1:0] == $past(ds_val[3:2]);
  endproperty
  a_exit_copy: assert property (p_exit_copy) else $error("exit copy missed");

  property p_exit_none;
    @(posedge CLK) disable iff (!ARST_N)
      s_exit_code(2'h0) |=> $stable(ds_val[1:0]);
  endproperty
  a_exit_none: assert property (p_exit_none) else $error("exit 00 changed mode");

  property p_ds_decode;
    @(posedge CLK) disable iff (!ARST_N)
      $changed(ds_val[1:0]) |=> DS_CONV_EN == ($past(ds_val[1:0]) != 2'h0)
        && DS_CONV_FPWM == ($past(ds_val[1:0]) == 2'h3);
  endproperty
  a_ds_decode: assert property (p_ds_decode) else $error("deep-sleep mode decode wrong");

  property p_psw_en;
    @(posedge CLK) disable iff (!ARST_N)
      (psw_val[1:0] == 2'h0) [*2] |-> !PSW_EN;
  endproperty
  a_psw_en: assert property (p_psw_en) else $error("switch enabled at mode 00");

  property p_v18_lp_apply;
    @(posedge CLK) disable iff (!ARST_N)
      enter_pulse |=> V18_LP_SEL == $past(v18_val[7:6])
        && V18_LP_ACTIVE == ($past(v18_val[7:6]) != 2'h0);
  endproperty
  a_v18_lp_apply: assert property (p_v18_lp_apply) else $error("1.8 V lp not applied");

  property p_v18_lp_none;
    @(posedge CLK) disable iff (!ARST_N)
      (enter_pulse && v18_val[7:6] == 2'h0) |=> !V18_LP_ACTIVE;
  endproperty
  a_v18_lp_none: assert property (p_v18_lp_none) else $error("1.8 V lp 00 active");

  property p_v18_write;
    @(posedge CLK) disable iff (!ARST_N)
      (wr_v18 && !exit_pulse) |=> v18_val == $past(wr_data)
        ##1 V18_CONV_FPWM == ($past(v18_val[1:0]) == 2'h3);
  endproperty
  a_v18_write: assert property (p_v18_write) else $error("1.8 V write or decode wrong");

  property p_exit_fpwm;
    @(posedge CLK) disable iff (!ARST_N)
      s_exit_code(2'h3) |=> ##1 DS_CONV_EN && DS_CONV_FPWM;
  endproperty
  a_exit_fpwm: assert property (p_exit_fpwm) else $error("exit 11 not forced pwm");

  property p_exit_auto;
    @(posedge CLK) disable iff (!ARST_N)
      s_exit_code(2'h1) |=> ##1 DS_CONV_EN && !DS_CONV_FPWM;
  endproperty
  a_exit_auto: assert property (p_exit_auto) else $error("exit 01 not automatic");

  property p_mode_hold;
    @(posedge CLK) disable iff (!ARST_N)
      (!exit_pulse && !wr_ds) |=> $stable(ds_val);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode moved without cause");

endmodule : rcr_top

// [rcr_pkg.sv]
// shared constants for the rail control register bank
package rcr_pkg;

  // register indices as printed, byte address is four times the index
  localparam logic [7:0] IDX_DEEP_SLEEP = 8'h32;
  localparam logic [7:0] IDX_PLAT_SWITCH = 8'h33;
  localparam logic [7:0] IDX_RAIL_1V8 = 8'h34;
  localparam logic [7:0] ADDR_DEEP_SLEEP = {IDX_DEEP_SLEEP[5:0], 2'h0};
  localparam logic [7:0] ADDR_PLAT_SWITCH = {IDX_PLAT_SWITCH[5:0], 2'h0};
  localparam logic [7:0] ADDR_RAIL_1V8 = {IDX_RAIL_1V8[5:0], 2'h0};

  // reset values
  localparam logic [7:0] RST_DEEP_SLEEP = 8'h2A;
  localparam logic [7:0] RST_PLAT_SWITCH = 8'h0A;
  localparam logic [7:0] RST_RAIL_1V8 = 8'h2A;

  // field positions
  localparam int LP_MSB = 7;
  localparam int LP_LSB = 6;
  localparam int VSEL_MSB = 5;
  localparam int VSEL_LSB = 4;
  localparam int EXIT_MSB = 3;
  localparam int EXIT_LSB = 2;
  localparam int MODE_MSB = 1;
  localparam int MODE_LSB = 0;

  // field codes
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_AUTO_A = 2'h1;
  localparam logic [1:0] MODE_AUTO_B = 2'h2;
  localparam logic [1:0] MODE_FPWM = 2'h3;
  localparam logic [1:0] EXIT_NONE = 2'h0;
  localparam logic [1:0] LP_NONE = 2'h0;
  localparam logic [1:0] VSEL_NOMINAL = 2'h2;

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : rcr_pkg

// [rcr_rail_reg.sv]
// one 8-bit rail control register with copy on standby exit
`timescale 1ns/1ps
module rcr_rail_reg #(
  parameter logic [7:0] RESET_VAL = 8'h2A
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // write and standby exit
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  input wire logic exit_pulse,
  // stored value
  output logic [7:0] value
);

  logic [7:0] value_reg;
  logic [7:0] value_next;

  // write lands first, so a field written in the exit cycle is the one copied
  always_comb begin
    value_next = wr_en ? wr_data : value_reg;
    if (exit_pulse && value_next[rcr_pkg::EXIT_MSB:rcr_pkg::EXIT_LSB] != rcr_pkg::EXIT_NONE) begin
      value_next[rcr_pkg::MODE_MSB:rcr_pkg::MODE_LSB] =
        value_next[rcr_pkg::EXIT_MSB:rcr_pkg::EXIT_LSB];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      value_reg <= RESET_VAL;
    end else begin
      value_reg <= value_next;
    end
  end

  assign value = value_reg;

endmodule : rcr_rail_reg

// [rcr_axil_slave.sv]
// axi4-lite slave front end, one write and one read at a time
`timescale 1ns/1ps
module rcr_axil_slave #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // write channels
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read channels
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // register side
  output logic wr_pulse,
  output logic [ADDR_W-1:0] wr_addr,
  output logic [7:0] wr_data,
  output logic wr_lane0,
  input wire logic wr_ok,
  output logic [ADDR_W-1:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic rd_ok
);

  logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
  logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
  logic [7:0] w_data_reg, w_data_next;
  logic w_lane_reg, w_lane_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [7:0] rdata_reg, rdata_next;

  assign awready = !aw_full_reg && !bvalid_reg;
  assign wready = !w_full_reg && !bvalid_reg;
  assign arready = !rvalid_reg;
  assign wr_pulse = aw_full_reg && w_full_reg && !bvalid_reg;
  assign wr_addr = aw_addr_reg;
  assign wr_data = w_data_reg;
  assign wr_lane0 = w_lane_reg;
  assign rd_addr = araddr;

  always_comb begin
    aw_full_next = aw_full_reg;
    aw_addr_next = aw_addr_reg;
    w_full_next = w_full_reg;
    w_data_next = w_data_reg;
    w_lane_next = w_lane_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    if (awvalid && awready) begin
      aw_full_next = 1'b1;
      aw_addr_next = awaddr;
    end
    if (wvalid && wready) begin
      w_full_next = 1'b1;
      w_data_next = wdata[7:0];
      w_lane_next = wstrb[0];
    end
    if (wr_pulse) begin
      aw_full_next = 1'b0;
      w_full_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = wr_ok ? rcr_pkg::RESP_OKAY : rcr_pkg::RESP_SLVERR;
    end else if (bvalid_reg && bready) begin
      bvalid_next = 1'b0;
    end
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (arvalid && arready) begin
      rvalid_next = 1'b1;
      rdata_next = rd_data;
      rresp_next = rd_ok ? rcr_pkg::RESP_OKAY : rcr_pkg::RESP_SLVERR;
    end else if (rvalid_reg && rready) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_full_reg <= 1'b0;
      w_data_reg <= 8'h00;
      w_lane_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 8'h00;
      rresp_reg <= 2'h0;
    end else begin
      aw_full_reg <= aw_full_next;
      aw_addr_reg <= aw_addr_next;
      w_full_reg <= w_full_next;
      w_data_reg <= w_data_next;
      w_lane_reg <= w_lane_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign rvalid = rvalid_reg;
  assign rresp = rresp_reg;
  assign rdata = {24'h000000, rdata_reg};

endmodule : rcr_axil_slave

// [rcr_top_tb.sv]
// self-checking testbench for the rail control register bank
`timescale 1ns/1ps
module rcr_top_tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic sleep_n = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, d;
  logic [1:0] resp;
  logic ds_en, ds_fp, ds_la, psw_en, v_en, v_fp, v_la;
  logic [1:0] ds_vs, ds_lp, v_vs, v_lp;
  int n_errors = 0;
  int cmp_count = 0;
  logic [31:0] seed = 32'hA42844B8;
  logic [31:0] rnd;
  int mdl[3];
  int lp[3];
  logic [7:0] adr[3];

  always #5 clk = ~clk;

  rcr_top rcr_top_inst (
    .CLK(clk), .ARST_N(arst_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .SLEEP_N(sleep_n),
    .DS_CONV_EN(ds_en), .DS_CONV_FPWM(ds_fp), .DS_VOLT_SEL(ds_vs), .DS_LP_SEL(ds_lp),
    .DS_LP_ACTIVE(ds_la), .PSW_EN(psw_en),
    .V18_CONV_EN(v_en), .V18_CONV_FPWM(v_fp), .V18_VOLT_SEL(v_vs), .V18_LP_SEL(v_lp),
    .V18_LP_ACTIVE(v_la)
  );

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // expected control outputs from the model registers and captured setpoints
  function automatic logic [14:0] exp_outs();
    logic [6:0] f[3];
    int m;
    for (int r = 0; r < 3; r++) begin
      m = mdl[r] & 3;
      f[r] = {m != 0, m == 3, 2'((mdl[r] >> 4) & 3), 2'(lp[r]), lp[r] != 0};
    end
    return {f[0], f[1][6], f[2]};
  endfunction : exp_outs

  task automatic print_verdict();
    $display("errors %0d, compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic hang();
    n_errors++;
    $display("wrong value at %0t: bus answer never came", $time);
  endtask : hang

  ////////////////////////////////////////////////////////////////////////////////
  // ready sampled at the falling edge: stable up to the next rising edge
  task automatic axi_write(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s,
                           output logic [1:0] rsp);
    logic ah, wh, bd;
    int n;
    bd = 1'b0;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!bd && n < 100) begin
      @(negedge clk);
      n++;
      ah = awvalid && awready;
      wh = wvalid && wready;
      bd = bvalid;
      rsp = bresp;
      @(posedge clk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (bd) bready <= 1'b0;
    end
    if (!bd) hang();
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rsp);
    logic ah, rd;
    int n;
    rd = 1'b0;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!rd && n < 100) begin
      @(negedge clk);
      n++;
      ah = arvalid && arready;
      rd = rvalid;
      v = rdata;
      rsp = rresp;
      @(posedge clk);
      if (ah) arvalid <= 1'b0;
      if (rd) rready <= 1'b0;
    end
    if (!rd) hang();
  endtask : axi_read

  task automatic wr(input int r, input logic [7:0] v, input logic s0);
    rnd = xs();
    axi_write(adr[r], {rnd[31:8], v}, {3'h0, s0}, resp);
    check(resp, rcr_pkg::RESP_OKAY, "write response");
    if (s0) mdl[r] = v;
  endtask : wr

  task automatic rd_all();
    for (int r = 0; r < 3; r++) begin
      axi_read(adr[r], d, resp);
      check(resp, rcr_pkg::RESP_OKAY, "read response");
      check(d, mdl[r], "register value");
    end
  endtask : rd_all

  // enable and fpwm outputs trail a register change by one edge; the volt selects follow it at once
  task automatic outs_chk();
    repeat (2) @(posedge clk);
    @(negedge clk);
    check({ds_en, ds_fp, ds_vs, ds_lp, ds_la, psw_en, v_en, v_fp, v_vs, v_lp, v_la},
          exp_outs(), "control outputs");
  endtask : outs_chk

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    adr[0] = rcr_pkg::ADDR_DEEP_SLEEP;
    adr[1] = rcr_pkg::ADDR_PLAT_SWITCH;
    adr[2] = rcr_pkg::ADDR_RAIL_1V8;
    mdl[0] = rcr_pkg::RST_DEEP_SLEEP;
    mdl[1] = rcr_pkg::RST_PLAT_SWITCH;
    mdl[2] = rcr_pkg::RST_RAIL_1V8;
    lp = '{0, 0, 0};
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    rd_all();
    outs_chk();
    // unmapped place: refused, nothing changes
    axi_write(8'hFC, 32'h000000FF, 4'hF, resp);
    check(resp, rcr_pkg::RESP_SLVERR, "unmapped write");
    axi_read(8'hFC, d, resp);
    check(resp, rcr_pkg::RESP_SLVERR, "unmapped read");
    check(d, 32'h0, "unmapped data");
    rd_all();
    // every mode code on every rail, random upper bits and strobe
    for (int m = 0; m < 4; m++) begin
      for (int r = 0; r < 3; r++) begin
        rnd = xs();
        wr(r, {rnd[7:2], 2'(m)}, rnd[8]);
      end
      rd_all();
      outs_chk();
    end
    // every setpoint and exit code through a standby cycle
    for (int k = 0; k < 4; k++) begin
      for (int r = 0; r < 3; r++) begin
        rnd = xs();
        wr(r, {2'(k), rnd[5:4], 2'(k + r), rnd[1:0]}, 1'b1);
      end
      @(posedge clk);
      sleep_n <= 1'b0;
      lp[0] = (mdl[0] >> 6) & 3;
      lp[2] = (mdl[2] >> 6) & 3;
      outs_chk();
      // a write in standby: mode takes effect, setpoint waits for next fall
      wr(2, 8'(mdl[2] ^ 32'hC1), 1'b1);
      outs_chk();
      @(posedge clk);
      sleep_n <= 1'b1;
      for (int r = 0; r < 3; r++) begin
        lp[r] = 0;
        if (((mdl[r] >> 2) & 3) != 0) mdl[r] = (mdl[r] & 32'hFC) | ((mdl[r] >> 2) & 3);
      end
      outs_chk();
      rd_all();
    end
    print_verdict();
  end
endmodule : rcr_top_tb
